// ---- design/sea_pkg.sv ----
package sea_pkg;
  localparam int unsigned NUM_PERIPH = 17;
  localparam int unsigned NUM_SRC = 15;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SERIAL1_IDX = 5;
  localparam logic [DATA_W-1:0] REG_ZERO = 32'h0000_0000;
  localparam logic [NUM_PERIPH-1:0] PERIPH_ZERO = 17'h0_0000;
  localparam logic [NUM_SRC-1:0] SRC_ZERO = 15'h0000;
  localparam logic [ADDR_W-1:0] OFF_SER1_FLAGS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_SER1_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_MISSED = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_TOP_PEND_SET = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_TOP_PEND_CLR = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_TOP_ENA_SET = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_TOP_ENA_CLR = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_TOP_PEND = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_TOP_ENA = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_REQ_LEVEL = 8'h30;
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_MISS_BIT = 0;
  localparam int unsigned IRQ_TAKEN_BIT = 1;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } sea_bus_s;
endpackage : sea_pkg

// ---- design/sea_event_aggregator.sv ----
// Overview of operation
// - The serial1 request (index 5) is the OR of its enabled pending flags; other requests pass through synchronised.
// - A mask bit of one enables its source; zero blocks it.
// - Writing one clears a flag; writing zero leaves it alone.
// - Flags set on events regardless of the mask.
// - Enabling an already pending flag forwards it at once.
// - Requests are levels held while any enabled flag stays set.
// - The serial1 request drops once no set flag is enabled, by clearing the flags or writing their mask bits to zero.
// - An event in the clearing cycle keeps the flag set.
// - No counting: a repeat event merges into the pending flag.
// - One missed bit per request, set by enabled repeat events.
// - Writing one clears a missed bit; zero has no effect.
// - Top level latches requests; taken only while top enable is set.
module sea_event_aggregator
  import sea_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic clkEn,
  input wire sea_pkg::sea_bus_s bus,
  output logic [sea_pkg::DATA_W-1:0] rdata,
  input wire logic [sea_pkg::NUM_SRC-1:0] serial1Event,
  input wire logic [sea_pkg::NUM_PERIPH-1:0] otherPeriphReq,
  input wire logic [sea_pkg::NUM_PERIPH-1:0] otherPeriphEvent,
  output logic [sea_pkg::NUM_PERIPH-1:0] topRequest,
  output logic [sea_pkg::NUM_PERIPH-1:0] topTaken,
  output logic irq
);
  import sea_pkg::*;

  // Events come from other clock domains, so two stages each
  logic [NUM_SRC-1:0] evMeta_r;
  logic [NUM_SRC-1:0] evSync_r;
  logic [NUM_PERIPH-1:0] reqMeta_r;
  logic [NUM_PERIPH-1:0] reqSync_r;
  logic [NUM_PERIPH-1:0] oevMeta_r;
  logic [NUM_PERIPH-1:0] oevSync_r;

  logic [NUM_SRC-1:0] serial1Flags_r;
  logic [NUM_SRC-1:0] serial1Flags_nxt;
  logic [NUM_SRC-1:0] serial1Mask_r;
  logic [NUM_PERIPH-1:0] missed_r;
  logic [NUM_PERIPH-1:0] missed_nxt;
  logic [NUM_PERIPH-1:0] topPend_r;
  logic [NUM_PERIPH-1:0] topEna_r;
  logic [IRQ_W-1:0] irqStatus_r;
  logic [IRQ_W-1:0] irqEnable_r;
  logic [NUM_PERIPH-1:0] secondLevelReq;
  logic [NUM_PERIPH-1:0] missEvent;
  logic [NUM_PERIPH-1:0] takenNow;
  logic serial1Req;
  logic [IRQ_W-1:0] irqEvent;

  logic [NUM_SRC-1:0] evPrev_r;
  logic [NUM_PERIPH-1:0] oevPrev_r;
  logic [NUM_PERIPH-1:0] reqPrev_r;
  logic [NUM_SRC-1:0] evRise;
  logic [NUM_PERIPH-1:0] oevRise;
  logic [NUM_PERIPH-1:0] topPend_nxt;
  logic [NUM_PERIPH-1:0] topEna_nxt;
  logic [IRQ_W-1:0] irqStatus_nxt;

  logic wrFlags;
  logic wrMask;
  logic wrMissed;
  logic wrPendSet;
  logic wrPendClr;
  logic wrEnaSet;
  logic wrEnaClr;
  logic wrIrqClr;
  logic wrIrqEna;

  function automatic logic wrHit(input sea_bus_s b, input logic [ADDR_W-1:0] off);
    wrHit = b.wr && (b.addr == off);
  endfunction : wrHit

  function automatic logic [NUM_PERIPH-1:0] low17(input logic [DATA_W-1:0] d);
    low17 = d[NUM_PERIPH-1:0];
  endfunction : low17

  // Decoded once; clkEn folded in so a frozen cycle never half-applies a write
  always_comb
  begin
    wrFlags = clkEn && wrHit(bus, OFF_SER1_FLAGS);
    wrMask = clkEn && wrHit(bus, OFF_SER1_MASK);
    wrMissed = clkEn && wrHit(bus, OFF_MISSED);
    wrPendSet = clkEn && wrHit(bus, OFF_TOP_PEND_SET);
    wrPendClr = clkEn && wrHit(bus, OFF_TOP_PEND_CLR);
    wrEnaSet = clkEn && wrHit(bus, OFF_TOP_ENA_SET);
    wrEnaClr = clkEn && wrHit(bus, OFF_TOP_ENA_CLR);
    wrIrqClr = clkEn && wrHit(bus, OFF_IRQ_CLEAR);
    wrIrqEna = clkEn && wrHit(bus, OFF_IRQ_ENABLE);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      evMeta_r <= SRC_ZERO;
      evSync_r <= SRC_ZERO;
      reqMeta_r <= PERIPH_ZERO;
      reqSync_r <= PERIPH_ZERO;
      oevMeta_r <= PERIPH_ZERO;
      oevSync_r <= PERIPH_ZERO;
    end
    else if (clkEn)
    begin
      evMeta_r <= serial1Event;
      evSync_r <= evMeta_r;
      reqMeta_r <= otherPeriphReq;
      reqSync_r <= reqMeta_r;
      oevMeta_r <= otherPeriphEvent;
      oevSync_r <= oevMeta_r;
    end
  end

  // One cycle behind the synchronisers; cleared to the idle low level
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      evPrev_r <= SRC_ZERO;
      oevPrev_r <= PERIPH_ZERO;
      reqPrev_r <= PERIPH_ZERO;
    end
    else if (clkEn)
    begin
      evPrev_r <= evSync_r;
      oevPrev_r <= oevSync_r;
      reqPrev_r <= reqSync_r;
    end
  end

  // A held level is one event; only its rising edge counts
  always_comb
  begin
    evRise = evSync_r & ~evPrev_r;
    oevRise = oevSync_r & ~oevPrev_r;
  end

  // Clear first, then set, so a new event in the clearing cycle survives
  always_comb
  begin
    serial1Flags_nxt = serial1Flags_r;
    if (wrFlags)
    begin
      serial1Flags_nxt = serial1Flags_nxt & ~bus.wdata[NUM_SRC-1:0];
    end
    serial1Flags_nxt = serial1Flags_nxt | evRise;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      serial1Flags_r <= SRC_ZERO;
    end
    else if (clkEn)
    begin
      serial1Flags_r <= serial1Flags_nxt;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      serial1Mask_r <= SRC_ZERO;
    end
    else if (wrMask)
    begin
      serial1Mask_r <= bus.wdata[NUM_SRC-1:0];
    end
  end

  // Combinational so enabling a pending flag forwards in the same cycle
  assign serial1Req = |(serial1Flags_r & serial1Mask_r);

  always_comb
  begin
    secondLevelReq = reqSync_r;
    secondLevelReq[SERIAL1_IDX] = serial1Req;
  end

  // Repeat of an enabled event while its flag is already pending
  always_comb
  begin
    // Others: event edge while their request already stood a cycle earlier
    missEvent = oevRise & reqPrev_r;
    missEvent[SERIAL1_IDX] = |(evRise & serial1Flags_r & serial1Mask_r);
  end

  always_comb
  begin
    missed_nxt = missed_r;
    if (wrMissed)
    begin
      missed_nxt = missed_nxt & ~low17(bus.wdata);
    end
    missed_nxt = missed_nxt | missEvent;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      missed_r <= PERIPH_ZERO;
    end
    else if (clkEn)
    begin
      missed_r <= missed_nxt;
    end
  end

  // Top-level latch; level request keeps re-pending while asserted
  always_comb
  begin
    topPend_nxt = topPend_r;
    if (wrPendClr)
    begin
      topPend_nxt = topPend_nxt & ~low17(bus.wdata);
    end
    if (wrPendSet)
    begin
      topPend_nxt = topPend_nxt | low17(bus.wdata);
    end
    topPend_nxt = topPend_nxt | secondLevelReq;
  end

  always_comb
  begin
    topEna_nxt = topEna_r;
    if (wrEnaClr)
    begin
      topEna_nxt = topEna_nxt & ~low17(bus.wdata);
    end
    if (wrEnaSet)
    begin
      topEna_nxt = topEna_nxt | low17(bus.wdata);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      topPend_r <= PERIPH_ZERO;
    end
    else if (clkEn)
    begin
      topPend_r <= topPend_nxt;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      topEna_r <= PERIPH_ZERO;
    end
    else if (clkEn)
    begin
      topEna_r <= topEna_nxt;
    end
  end

  assign topRequest = secondLevelReq;
  // Taken needs both the latch and the enable
  assign takenNow = topPend_r & topEna_r;
  assign topTaken = takenNow;

  always_comb
  begin
    irqEvent = '0;
    irqEvent[IRQ_MISS_BIT] = |missEvent;
    irqEvent[IRQ_TAKEN_BIT] = |takenNow;
  end

  // Set beats clear
  always_comb
  begin
    irqStatus_nxt = irqStatus_r;
    if (wrIrqClr)
    begin
      irqStatus_nxt = irqStatus_nxt & ~bus.wdata[IRQ_W-1:0];
    end
    irqStatus_nxt = irqStatus_nxt | irqEvent;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      irqStatus_r <= '0;
    end
    else if (clkEn)
    begin
      irqStatus_r <= irqStatus_nxt;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      irqEnable_r <= '0;
    end
    else if (wrIrqEna)
    begin
      irqEnable_r <= bus.wdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irqStatus_r & irqEnable_r);

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rdata <= REG_ZERO;
    end
    else if (clkEn)
    begin
      // Zero between reads keeps a stale word off the bus
      rdata <= REG_ZERO;
      if (bus.rd)
      begin
        unique case (bus.addr)
          OFF_SER1_FLAGS: rdata <= {{(DATA_W-NUM_SRC){1'b0}}, serial1Flags_r};
          OFF_SER1_MASK: rdata <= {{(DATA_W-NUM_SRC){1'b0}}, serial1Mask_r};
          OFF_MISSED: rdata <= {{(DATA_W-NUM_PERIPH){1'b0}}, missed_r};
          OFF_TOP_PEND: rdata <= {{(DATA_W-NUM_PERIPH){1'b0}}, topPend_r};
          OFF_TOP_ENA: rdata <= {{(DATA_W-NUM_PERIPH){1'b0}}, topEna_r};
          OFF_IRQ_STATUS: rdata <= {{(DATA_W-IRQ_W){1'b0}}, irqStatus_r};
          OFF_IRQ_ENABLE: rdata <= {{(DATA_W-IRQ_W){1'b0}}, irqEnable_r};
          OFF_REQ_LEVEL: rdata <= {{(DATA_W-NUM_PERIPH){1'b0}}, secondLevelReq};
          // Write-only and unmapped offsets read zero
          default: rdata <= REG_ZERO;
        endcase
      end
    end
  end
endmodule : sea_event_aggregator

// ---- tb/sea_chk.sv ----
module sea_chk
  import sea_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic clkEn,
  input wire sea_pkg::sea_bus_s bus,
  input wire logic [31:0] rdata,
  input wire logic [16:0] otherPeriphReq,
  input wire logic [16:0] topRequest,
  input wire logic [16:0] topTaken,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (srst);
  sequence s_wr(logic [7:0] a, logic [16:0] d);
    clkEn && bus.wr && bus.addr == a && bus.wdata[16:0] == d;
  endsequence
  property p_rst; $fell(srst) |-> !topRequest && !topTaken && !irq; endproperty
  a_rst: assert property (p_rst) else $error("not idle");
  property p_rdIdle; clkEn && !bus.rd |=> !rdata; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("stray data");
  property p_rdHole; clkEn && bus.rd && bus.addr == 8'hfc |=> !rdata; endproperty
  a_rdHole: assert property (p_rdHole) else $error("hole read");
  property p_hold; topRequest[5] && !bus.wr |=> topRequest[5]; endproperty
  a_hold: assert property (p_hold) else $error("req dropped");
  property p_mask0; s_wr(8'h04, 17'h0) |=> !topRequest[5]; endproperty
  a_mask0: assert property (p_mask0) else $error("masked req");
  property p_enaClr; s_wr(8'h18, 17'h1ffff) |=> !topTaken; endproperty
  a_enaClr: assert property (p_enaClr) else $error("taken");
  property p_irqOff; s_wr(8'h2c, 17'h0) |=> !irq; endproperty
  a_irqOff: assert property (p_irqOff) else $error("irq on");
  // Two synchroniser stages; serial slot is local
  property p_pass;
    $past(clkEn) && $past(clkEn, 2) && !$past(srst) && !$past(srst, 2)
      |-> !((topRequest ^ $past(otherPeriphReq, 2)) & 17'h1ffdf);
  endproperty
  a_pass: assert property (p_pass) else $error("pass req");
endmodule : sea_chk

bind sea_event_aggregator sea_chk i_chk (.mclk(mclk), .srst(srst), .clkEn(clkEn),
  .bus(bus), .rdata(rdata), .otherPeriphReq(otherPeriphReq),
  .topRequest(topRequest), .topTaken(topTaken), .irq(irq));

// ---- tb/sea_src_model.sv ----
module sea_src_model
  import sea_pkg::*;
#(
  parameter int HOLD = 3
)
(
  input wire logic mclk,
  input wire logic [14:0] fire,
  input wire logic [16:0] reqIn,
  output logic [14:0] serial1Event,
  output logic [16:0] otherPeriphReq,
  output logic [16:0] otherPeriphEvent
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic [14:0] held = 15'h0;
  // Event held a few cycles, then dropped
  always_ff @(posedge mclk)
  begin
    if (fire != 15'h0)
    begin
      held <= fire;
      cnt <= HOLD;
    end
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  assign serial1Event = (cnt != 0) ? held : 15'h0;
  assign otherPeriphReq = reqIn;
  assign otherPeriphEvent = reqIn;
endmodule : sea_src_model

// ---- tb/second_level_event_aggregator_tb_top.sv ----
module second_level_event_aggregator_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sea_pkg::*;
  localparam logic [7:0] ADR[5] = '{8'h00, 8'h04, 8'h08, 8'h1c, 8'hfc};
  logic mclk = 1'h0;
  logic srst = 1'h1;
  logic rdLag = 1'h0;
  logic clkEn = 1'h1;
  logic irq;
  sea_bus_s bus = '0;
  logic [31:0] rdata;
  logic [31:0] m;
  logic [31:0] f;
  logic [14:0] fire = 15'h0;
  logic [14:0] ev;
  logic [16:0] reqIn = 17'h0;
  logic [16:0] oReq;
  logic [16:0] oEv;
  logic [16:0] topRequest;
  logic [16:0] topTaken;
  logic [31:0] expQ[$];
  int bad_count = 0;
  int total_checks = 0;
  sea_src_model i_src (.mclk(mclk), .fire(fire), .reqIn(reqIn), .serial1Event(ev),
    .otherPeriphReq(oReq), .otherPeriphEvent(oEv));
  sea_event_aggregator i_dut (.mclk(mclk), .srst(srst), .clkEn(clkEn), .bus(bus),
    .rdata(rdata), .serial1Event(ev), .otherPeriphReq(oReq), .otherPeriphEvent(oEv),
    .topRequest(topRequest), .topTaken(topTaken), .irq(irq));
  initial forever #20 mclk = ~mclk;
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic lv(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask : lv
  task automatic op(input logic [7:0] a, input logic [31:0] d, input logic w);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge mclk);
  endtask : op
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    op(a, '0, 1'h0);
  endtask : rd
  task automatic wt(input int n);
    bus <= '0;
    repeat (n) @(posedge mclk);
  endtask : wt
  task automatic hit(input logic [14:0] b);
    bus <= '0;
    fire <= b;
    @(posedge mclk);
    fire <= 15'h0;
    repeat (10) @(posedge mclk);
  endtask : hit
  // Read data only valid one cycle after the strobe
  always @(posedge mclk)
  begin
    if (rdLag)
      chk(rdata, expQ.pop_front());
    rdLag <= bus.rd;
  end
  initial
  begin
    #400us;
    bad_count++;
    summarize();
  end
  initial
  begin
    m = $urandom(32'h571529f1);
    repeat (8) @(posedge mclk);
    srst <= 1'h0;
    wt(2);
    chk(32'(topRequest), 32'h0);
    foreach (ADR[i])
      rd(ADR[i], '0);
    $display("T1 done");
    hit(15'h0008);
    rd(8'h00, 32'h8);
    rd(8'h08, '0);
    wt(1);
    lv(topRequest[5], 1'h0);
    op(8'h04, 32'h8, 1'h1);
    wt(1);
    lv(topRequest[5], 1'h1);
    op(8'h00, '0, 1'h1);
    rd(8'h00, 32'h8);
    op(8'h00, 32'h8, 1'h1);
    wt(1);
    lv(topRequest[5], 1'h0);
    $display("T2 done");
    repeat (4)
    begin
      m = $urandom & 32'h7fff;
      f = $urandom & 32'h7fff;
      op(8'h04, m, 1'h1);
      hit(f[14:0]);
      rd(8'h00, f);
      wt(1);
      lv(topRequest[5], |(f & m));
      op(8'h00, 32'h7fff, 1'h1);
    end
    $display("T3 done");
    op(8'h08, 32'h1ffff, 1'h1);
    op(8'h04, 32'h1, 1'h1);
    hit(15'h1);
    rd(8'h08, '0);
    hit(15'h1);
    rd(8'h00, 32'h1);
    rd(8'h08, 32'h20);
    op(8'h08, '0, 1'h1);
    rd(8'h08, 32'h20);
    op(8'h08, 32'h20, 1'h1);
    rd(8'h08, '0);
    $display("T4 done");
    op(8'h04, '0, 1'h1);
    bus <= '0;
    fire <= 15'h2;
    @(posedge mclk);
    fire <= 15'h0;
    repeat (2) @(posedge mclk);
    // Clear lands on the edge that sees the synced rise
    op(8'h00, 32'h3, 1'h1);
    wt(10);
    rd(8'h00, 32'h2);
    $display("T5 done");
    op(8'h00, 32'h1, 1'h1);
    hit(15'h1);
    op(8'h04, 32'h1, 1'h1);
    wt(2);
    lv(topTaken[5], 1'h0);
    op(8'h14, 32'h20, 1'h1);
    wt(1);
    lv(topTaken[5], 1'h1);
    op(8'h18, 32'h1ffff, 1'h1);
    $display("T6 done");
    op(8'h2c, 32'h1, 1'h1);
    wt(1);
    lv(irq, 1'h1);
    op(8'h2c, '0, 1'h1);
    op(8'h28, 32'h3, 1'h1);
    op(8'h2c, 32'h3, 1'h1);
    op(8'h00, 32'h7fff, 1'h1);
    rd(8'h24, '0);
    wt(1);
    lv(irq, 1'h0);
    reqIn <= 17'h10121;
    wt(3);
    chk(32'(topRequest), 32'h10101);
    $display("T7 done");
    clkEn <= 1'h0;
    op(8'h04, 32'h7fff, 1'h1);
    clkEn <= 1'h1;
    rd(8'h04, 32'h1);
    wt(2);
    $display("T8 done");
    summarize();
  end
endmodule : second_level_event_aggregator_tb_top
